// file: common/slp_pkg.sv
// Constants and types shared by the status lamp pattern generator
package slp_pkg;
	localparam int         CLK_HZ        = 100_000_000;
	localparam int         TICKS_PER_SEC = 24;
	localparam int         SUB_CYCLES    = CLK_HZ / TICKS_PER_SEC;
	localparam logic [4:0] SUB_LAST      = 5'h17;
	localparam logic [4:0] FLASH_ON      = 5'h03;
	localparam logic [4:0] RAPID_TICKS   = 5'h03;
	localparam logic [4:0] POWERUP_TICKS = 5'h0c;
	localparam logic [3:0] RETRY_SEC     = 4'h5;
	localparam logic [2:0] FLASH_ONE     = 3'h1;
	localparam logic [2:0] FLASH_TWO     = 3'h2;
	localparam logic [2:0] FLASH_THREE   = 3'h3;
	localparam logic [2:0] FLASH_FOUR    = 3'h4;

	typedef enum logic [5:0] {
		M_PWRUP  = 6'h01,
		M_PROG   = 6'h02,
		M_ERR    = 6'h04,
		M_NOSET  = 6'h08,
		M_SLEEP  = 6'h10,
		M_NORMAL = 6'h20
	} slp_mode_e;
endpackage

// file: common/slp_tick_if.sv
// Prescaled tick bundle between the prescaler and the pattern logic
`timescale 1ns/100ps
`default_nettype none
interface slp_tick_if;
	logic       tick;
	logic [4:0] subIdx;
	logic       secOdd;
	modport src (output tick, output subIdx, output secOdd);
	modport dst (input tick, input subIdx, input secOdd);
endinterface
`default_nettype wire

// file: dv/slp_lamp_model.sv
// Lamp model: watches both bicolour lamps and tallies flashes over a window
`timescale 1ns/100ps
`default_nettype none
module slp_lamp_model (
	input  wire logic        clk,
	input  wire logic        netRed,
	input  wire logic        netGreen,
	input  wire logic        posRed,
	input  wire logic        posGreen,
	input  wire logic        antEn,
	input  wire logic        measReq,
	input  wire logic [7:0]  measLen,
	output logic             measDone,
	output logic [22:0]      measRes
);
	logic [3:0] lit;
	logic [3:0] prevLit = 4'h0;
	logic [7:0] left    = 8'h00;
	logic       busy    = 1'h0;

	// What the eye sees, network lamp in the upper pair
	assign lit = {netRed, netGreen, posRed, posGreen};

	// First look, rise counts, same-pattern flag and no-double-red flag
	always_ff @(posedge clk) begin
		prevLit  <= lit;
		measDone <= 1'h0;
		if (measReq) begin
			busy    <= 1'h1;
			left    <= measLen;
			measRes <= {lit, antEn, 16'h0000, 2'h3};
		end else if (busy) begin
			for (int i = 0; i < 4; i++) begin
				if (lit[i] && !prevLit[i]) begin
					measRes[2 + 4 * i +: 4] <= measRes[2 + 4 * i +: 4] + 4'h1;
				end
			end
			if (lit[3:2] != lit[1:0]) begin
				measRes[1] <= 1'h0;
			end
			if (lit[3] && lit[1]) begin
				measRes[0] <= 1'h0;
			end
			left <= left - 8'h01;
			if (left == 8'h01) begin
				busy     <= 1'h0;
				measDone <= 1'h1;
			end
		end
	end
endmodule
`default_nettype wire

// file: dv/slp_top_bench.sv
// Self-checking bench for the status lamp pattern generator
`timescale 1ns/100ps
`default_nettype none
module slp_top_bench;
	localparam int          SUBC = 4;
	localparam logic [22:0] CNT  = 23'h03fffc;
	localparam logic [22:0] ANT  = 23'h0403fc;
	logic        clk = 1'h0;
	logic        arst_n = 1'h0;
	logic        noSettings = 1'h0, programming = 1'h0, errorState = 1'h0, sleeping = 1'h0;
	logic        gpsPowerOff = 1'h0, netSignal = 1'h0, serverOk = 1'h0, dataPending = 1'h0;
	logic        alarmAcked = 1'h0, alarmWaitAck = 1'h0, gpsSignal = 1'h0, antShortPin = 1'h0;
	logic        netR, netG, posR, posG, antEn;
	logic        measReq = 1'h0;
	logic [7:0]  measLen = 8'h00;
	logic        measDone;
	logic [22:0] measRes;
	logic [45:0] expQ[$];
	logic [45:0] note;
	logic [31:0] rnd = 32'h9e1dcb52;
	int          numErrors = 0;
	int          totalChecks = 0;
	logic [22:0] stackExp[4] = '{{5'h00, 16'h8888, 2'h2}, {5'h00, 16'h8080, 2'h1},
		{5'h00, 16'h1111, 2'h2}, {5'h00, 16'h1100, 2'h1}};

	////////////////////////////////////////////////////////////////
	// Clock and the parts under test
	always #5 clk = ~clk;

	slp_top #(.SUB_CYCLES(SUBC)) DUT (
		.clk              (clk),
		.arst_n           (arst_n),
		.noSettings       (noSettings),
		.programming      (programming),
		.errorState       (errorState),
		.sleeping         (sleeping),
		.gpsPowerOff      (gpsPowerOff),
		.netSignal        (netSignal),
		.serverOk         (serverOk),
		.dataPending      (dataPending),
		.alarmAcked       (alarmAcked),
		.alarmWaitAck     (alarmWaitAck),
		.gpsSignal        (gpsSignal),
		.antShortPin      (antShortPin),
		.networkLampRed   (netR),
		.networkLampGreen (netG),
		.posLampRed       (posR),
		.posLampGreen     (posG),
		.antPowerEn       (antEn)
	);

	slp_lamp_model lamps (
		.clk      (clk),
		.netRed   (netR),
		.netGreen (netG),
		.posRed   (posR),
		.posGreen (posG),
		.antEn    (antEn),
		.measReq  (measReq),
		.measLen  (measLen),
		.measDone (measDone),
		.measRes  (measRes)
	);

	////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xorShift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic endOfTest();
		if (numErrors == 0 && totalChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Note the expectation, open a window, wait for it to close
	task automatic measure(input logic [22:0] expVal, input logic [22:0] care, input logic [7:0] len);
		int n;
		expQ.push_back({care, expVal});
		measLen <= len;
		measReq <= 1'h1;
		@(posedge clk);
		measReq <= 1'h0;
		n = 0;
		while (measDone !== 1'h1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n >= 300) begin
			numErrors++;
			$display("[FAIL] %0t exp=%h got=%h", $time, 1'h1, measDone);
			endOfTest();
		end
	endtask

	// Compare each finished window against the oldest note
	always @(posedge clk) begin
		if (measDone === 1'h1) begin
			note = expQ.pop_front();
			totalChecks++;
			if ((measRes & note[45:23]) !== (note[22:0] & note[45:23])) begin
				numErrors++;
				$display("[FAIL] %0t exp=%h got=%h", $time, note[22:0], measRes);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [3:0]  n;
		logic        off;
		int          w;
		repeat (5) @(posedge clk);
		arst_n <= 1'h1;
		@(posedge clk);
		programming <= 1'h1;
		@(posedge clk);
		measure({5'h0b, 16'h0000, 2'h3}, 23'h7fffff, 8'h24);
		errorState <= 1'h1;
		noSettings <= 1'h1;
		sleeping   <= 1'h1;
		repeat (30) @(posedge clk);
		for (int k = 0; k < 4; k++) begin
			measure(stackExp[k], CNT | 23'h3, 8'hc0);
			programming <= 1'h0;
			errorState  <= (k < 1);
			noSettings  <= (k < 2);
			sleeping    <= (k < 3);
			repeat (2) @(posedge clk);
		end
		for (int k = 0; k < 8; k++) begin
			rnd = xorShift(rnd);
			off = (k == 5) | (rnd[3] & rnd[4]);
			netSignal    <= rnd[0];
			serverOk     <= rnd[1];
			gpsSignal    <= rnd[2];
			gpsPowerOff  <= off;
			alarmWaitAck <= (k % 4 == 3);
			alarmAcked   <= (k % 4 == 2) | ((k % 4 == 3) & rnd[5]);
			dataPending  <= (k % 4 == 1) | ((k % 4 > 1) & rnd[6]);
			repeat (2) @(posedge clk);
			n = 4'(2 * (k % 4 + 1));
			measure({5'h00, (!rnd[0] || !rnd[1]) ? n : 4'h0, rnd[0] ? n : 4'h0,
				(!off && !rnd[2]) ? 4'h2 : 4'h0, (!off && rnd[2]) ? 4'h2 : 4'h0, 2'h0}, CNT, 8'hc0);
		end
		gpsPowerOff <= 1'h0;
		gpsSignal   <= 1'h1;
		antShortPin <= 1'h1;
		repeat (10) @(posedge clk);
		measure({5'h00, 16'h0008, 2'h0}, ANT, 8'hc0);
		antShortPin <= 1'h0;
		w = 0;
		while (antEn !== 1'h1 && w < 800) begin
			@(posedge clk);
			w++;
		end
		if (w >= 800) begin
			numErrors++;
			$display("[FAIL] %0t exp=%h got=%h", $time, 1'h1, antEn);
			endOfTest();
		end
		repeat (2) @(posedge clk);
		measure({5'h01, 16'h0002, 2'h0}, ANT, 8'hc0);
		endOfTest();
	end
endmodule
`default_nettype wire

// file: src/slp_tick.sv
// Prescaler: 24 sub-ticks per second plus second parity
`timescale 1ns/100ps
`default_nettype none
module slp_tick #(
	parameter int SUB_CYCLES = slp_pkg::SUB_CYCLES
) (
	input  wire logic clk,
	input  wire logic arst_n,
	slp_tick_if.src   tk
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
		logic [4:0]  subIdx;
		logic        secOdd;
	} slp_tick_s;

	slp_tick_s st_reg;
	slp_tick_s st_next;

	////////////////////////////////////////////////////////////////
	// Next state: cycle counter, sub-tick index, second parity
	// shared tick base
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt >= 32'(SUB_CYCLES - 1)) begin
			st_next.cnt = 32'h0;
			st_next.tick = 1'b1;
			if (st_reg.subIdx == slp_pkg::SUB_LAST) begin
				st_next.subIdx = 5'h00;
				st_next.secOdd = ~st_reg.secOdd;
			end else begin
				st_next.subIdx = st_reg.subIdx + 5'h01;
			end
		end else begin
			st_next.cnt = st_reg.cnt + 32'h1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tk.tick   = st_reg.tick;
	assign tk.subIdx = st_reg.subIdx;
	assign tk.secOdd = st_reg.secOdd;

	////////////////////////////////////////////////////////////////
	// single tick base
	AST_SUB_RANGE: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg.subIdx <= slp_pkg::SUB_LAST)
		else $error("sub-tick index out of range");
endmodule
`default_nettype wire

// file: src/slp_top.sv
// Status lamp pattern generator for the network and positioning lamps
//
// Operation
// - After power-up both lamps show green briefly before anything else.
// - No settings: both lamps swap red and green together each second.
// - Programming: both lamps swap red and green rapidly.
// - Error: lamps flash red rapidly, one lit while the other is dark.
// - Sleeping: network lamp flashes orange every two seconds, positioning lamp dark.
// - Network colour: red no signal, green all ok, both when server unreachable.
// - Network flashes per second: one empty, two data, three acked, four awaiting.
// - Positioning lamp red without satellite signal, green with good signal.
// - Positioning lamp one flash per second healthy, four when antenna shorted.
// - Periodic wakeup with receiver off keeps positioning lamp dark.
// - Antenna short removes supply, supply is retried periodically until clear.
`timescale 1ns/100ps
`default_nettype none
module slp_top #(
	parameter int SUB_CYCLES = slp_pkg::SUB_CYCLES
) (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic noSettings,
	input  wire logic programming,
	input  wire logic errorState,
	input  wire logic sleeping,
	input  wire logic gpsPowerOff,
	input  wire logic netSignal,
	input  wire logic serverOk,
	input  wire logic dataPending,
	input  wire logic alarmAcked,
	input  wire logic alarmWaitAck,
	input  wire logic gpsSignal,
	input  wire logic antShortPin,
	output logic      networkLampRed,
	output logic      networkLampGreen,
	output logic      posLampRed,
	output logic      posLampGreen,
	output logic      antPowerEn
);
	typedef struct packed {
		slp_pkg::slp_mode_e mode;
		logic [4:0]         pwrCnt;
		logic               pwrDone;
		logic               shortS1;
		logic               shortS2;
		logic               shortS3;
		logic               shortSeen;
		logic               antOn;
		logic [3:0]         retryCnt;
		logic               netR;
		logic               netG;
		logic               posR;
		logic               posG;
	} slp_state_s;

	slp_state_s st_reg;
	slp_state_s st_next;
	slp_tick_if tk ();

	////////////////////////////////////////////////////////////////
	// Prescaler
	slp_tick #(
		.SUB_CYCLES (SUB_CYCLES)
	) u_tick (
		.clk    (clk),
		.arst_n (arst_n),
		.tk     (tk.src)
	);

	////////////////////////////////////////////////////////////////
	// Flash window: n flashes evenly spaced within one second
	function automatic logic flashOn(input logic [4:0] s, input logic [2:0] n);
		logic [4:0] per;
		per = 5'h18;
		case (n)
			slp_pkg::FLASH_TWO:   per = 5'h0c;
			slp_pkg::FLASH_THREE: per = 5'h08;
			slp_pkg::FLASH_FOUR:  per = 5'h06;
			default:              per = 5'h18;
		endcase
		return (s % per) < slp_pkg::FLASH_ON;
	endfunction

	// Rapid phase used by programming and error patterns
	function automatic logic rapidPhase(input logic [4:0] s);
		logic [4:0] q;
		q = s / slp_pkg::RAPID_TICKS;
		return q[0];
	endfunction

	logic       netOn;
	logic       posOn;
	logic [2:0] netCount;
	logic       phase;

	////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_next = st_reg;
		netOn = 1'b0;
		posOn = 1'b0;
		netCount = slp_pkg::FLASH_ONE;
		phase = rapidPhase(tk.subIdx);

		// Power-up interval counted in sub-ticks
		if (!st_reg.pwrDone && tk.tick) begin
			st_next.pwrCnt = st_reg.pwrCnt + 5'h01;
			if (st_next.pwrCnt == slp_pkg::POWERUP_TICKS) begin
				st_next.pwrDone = 1'b1;
			end
		end

		// Short pin synchroniser, change taken when stages two and three agree
		st_next.shortS1 = antShortPin;
		st_next.shortS2 = st_reg.shortS1;
		st_next.shortS3 = st_reg.shortS2;
		if (st_reg.shortS2 == st_reg.shortS3) begin
			st_next.shortSeen = st_reg.shortS3;
		end

		if (st_reg.antOn) begin
			if (st_reg.shortSeen) begin
				st_next.antOn = 1'b0;
				st_next.retryCnt = 4'h0;
			end
		end else if (tk.tick && tk.subIdx == 5'h00) begin
			st_next.retryCnt = st_reg.retryCnt + 4'h1;
			if (st_next.retryCnt == slp_pkg::RETRY_SEC) begin
				st_next.antOn = 1'b1;
			end
		end

		if (!st_next.pwrDone) begin
			st_next.mode = slp_pkg::M_PWRUP;
		end else if (programming) begin
			st_next.mode = slp_pkg::M_PROG;
		end else if (errorState) begin
			st_next.mode = slp_pkg::M_ERR;
		end else if (noSettings) begin
			st_next.mode = slp_pkg::M_NOSET;
		end else if (sleeping) begin
			st_next.mode = slp_pkg::M_SLEEP;
		end else begin
			st_next.mode = slp_pkg::M_NORMAL;
		end

		if (alarmWaitAck) begin
			netCount = slp_pkg::FLASH_FOUR;
		end else if (alarmAcked) begin
			netCount = slp_pkg::FLASH_THREE;
		end else if (dataPending) begin
			netCount = slp_pkg::FLASH_TWO;
		end

		// Lamp patterns per mode
		case (st_next.mode)
			slp_pkg::M_PWRUP: begin
				st_next.netR = 1'b0;
				st_next.netG = 1'b1;
				st_next.posR = 1'b0;
				st_next.posG = 1'b1;
			end
			slp_pkg::M_PROG: begin
				st_next.netR = phase;
				st_next.netG = ~phase;
				st_next.posR = phase;
				st_next.posG = ~phase;
			end
			slp_pkg::M_ERR: begin
				st_next.netR = phase;
				st_next.netG = 1'b0;
				st_next.posR = ~phase;
				st_next.posG = 1'b0;
			end
			slp_pkg::M_NOSET: begin
				st_next.netR = tk.secOdd;
				st_next.netG = ~tk.secOdd;
				st_next.posR = tk.secOdd;
				st_next.posG = ~tk.secOdd;
			end
			slp_pkg::M_SLEEP: begin
				netOn = !tk.secOdd && (tk.subIdx < slp_pkg::FLASH_ON);
				st_next.netR = netOn;
				st_next.netG = netOn;
				st_next.posR = 1'b0;
				st_next.posG = 1'b0;
			end
			slp_pkg::M_NORMAL: begin
				netOn = flashOn(tk.subIdx, netCount);
				st_next.netR = netOn && (!netSignal || !serverOk);
				st_next.netG = netOn && netSignal;
				// antenna health rate, dark when receiver off
				posOn = !gpsPowerOff && flashOn(tk.subIdx,
					st_next.antOn ? slp_pkg::FLASH_ONE : slp_pkg::FLASH_FOUR);
				st_next.posR = posOn && !gpsSignal;
				st_next.posG = posOn && gpsSignal;
			end
			default: begin
				st_next.netR = 1'b0;
				st_next.netG = 1'b0;
				st_next.posR = 1'b0;
				st_next.posG = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
			st_reg.mode <= slp_pkg::M_PWRUP;
			st_reg.antOn <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign networkLampRed   = st_reg.netR;
	assign networkLampGreen = st_reg.netG;
	assign posLampRed       = st_reg.posR;
	assign posLampGreen     = st_reg.posG;
	assign antPowerEn       = st_reg.antOn;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	logic [4:0] subPrev;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			subPrev <= 5'h00;
		end else begin
			subPrev <= tk.subIdx;
		end
	end

	AST_PWRUP_GREEN: assert property ($past(arst_n) && st_reg.mode == slp_pkg::M_PWRUP |->
		networkLampGreen && posLampGreen && !networkLampRed && !posLampRed)
		else $error("power-up lamps not green");
	AST_NOSET_SWAP: assert property (st_reg.mode == slp_pkg::M_NOSET |->
		networkLampRed != networkLampGreen && networkLampRed == posLampRed)
		else $error("no-settings swap broken");
	AST_PROG_SWAP: assert property ($past(programming) && st_reg.pwrDone |->
		st_reg.mode == slp_pkg::M_PROG && posLampRed == networkLampRed && posLampGreen != posLampRed)
		else $error("programming pattern broken");
	AST_ERR_ALT: assert property (st_reg.mode == slp_pkg::M_ERR |->
		!networkLampGreen && !posLampGreen && networkLampRed != posLampRed)
		else $error("error alternation broken");
	AST_SLEEP_DARK: assert property (st_reg.mode == slp_pkg::M_SLEEP |->
		!posLampRed && !posLampGreen && networkLampRed == networkLampGreen)
		else $error("sleep pattern broken");
	AST_NET_COLOUR: assert property (st_reg.mode == slp_pkg::M_NORMAL && networkLampGreen |->
		$past(netSignal) && (networkLampRed == !$past(serverOk)))
		else $error("network colour wrong");
	AST_NET_ONE: assert property (st_reg.mode == slp_pkg::M_NORMAL && (networkLampRed || networkLampGreen)
		&& $past(!dataPending && !alarmAcked && !alarmWaitAck) |-> subPrev < slp_pkg::FLASH_ON)
		else $error("single network flash outside window");
	AST_POS_COLOUR: assert property (st_reg.mode == slp_pkg::M_NORMAL && posLampGreen |->
		$past(gpsSignal) && !posLampRed)
		else $error("positioning colour wrong");
	AST_POS_RATE: assert property (st_reg.mode == slp_pkg::M_NORMAL && antPowerEn
		&& (posLampRed || posLampGreen) |-> subPrev < slp_pkg::FLASH_ON)
		else $error("healthy antenna flash outside window");
	AST_POS_OFF: assert property (st_reg.mode == slp_pkg::M_NORMAL && $past(gpsPowerOff) |->
		!posLampRed && !posLampGreen)
		else $error("positioning lamp lit with receiver off");
	AST_ANT_CUT: assert property (antPowerEn && st_reg.shortSeen |=> !antPowerEn)
		else $error("antenna supply not removed on short");
	AST_PRIO_ERR: assert property ($past(errorState && !programming) && st_reg.pwrDone |->
		st_reg.mode == slp_pkg::M_ERR)
		else $error("error state priority wrong");

	COV_NORMAL: cover property (st_reg.mode == slp_pkg::M_PWRUP ##1 st_reg.mode == slp_pkg::M_NORMAL);
	COV_ANT_RETRY: cover property ($fell(antPowerEn) ##[1:1000] $rose(antPowerEn));
	COV_ERR: cover property (st_reg.mode == slp_pkg::M_ERR && networkLampRed);
	COV_SLEEP: cover property (st_reg.mode == slp_pkg::M_SLEEP && networkLampRed);
endmodule
`default_nettype wire
